/* File: lcaf_pkg.sv */
// package: register map, field positions, reset values and scaling shifts
package lcaf_pkg;
    localparam int ADDR_W = 6;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 6'h0B;
    localparam logic [ADDR_W-1:0] ADDR_SHUNT_HIGH = 6'h0C;
    localparam logic [ADDR_W-1:0] ADDR_SHUNT_LOW = 6'h0D;
    localparam logic [ADDR_W-1:0] ADDR_BUS_HIGH = 6'h0E;
    localparam logic [ADDR_W-1:0] ADDR_BUS_LOW = 6'h0F;
    localparam int BIT_LATCH = 15;
    localparam int BIT_SHUNT_OVER = 6;
    localparam int BIT_SHUNT_UNDER = 5;
    localparam int BIT_BUS_OVER = 4;
    localparam int BIT_BUS_UNDER = 3;
    localparam int BIT_POWER_OVER = 2;
    localparam int BIT_CONV_DONE = 1;
    localparam int BIT_MEM_OK = 0;
    localparam logic [15:0] RST_SHUNT_HIGH = 16'h7FFF;
    localparam logic [15:0] RST_SHUNT_LOW = 16'h8000;
    localparam logic [14:0] RST_BUS_HIGH = 15'h7FFF;
    localparam logic [14:0] RST_BUS_LOW = 15'h0000;
    localparam logic RST_LATCH = 1'b0;
    localparam logic RST_MEM_OK = 1'b1;
    // threshold lsb versus result lsb: 5 uV / 312.5 nV and 1.25 uV / 78.125 nV
    localparam int SHIFT_SHUNT_WIDE = 4;
    localparam int SHIFT_SHUNT_NARROW = 4;
    // 3.125 mV / 195.3125 uV, and 256 power lsb
    localparam int SHIFT_BUS = 4;
    localparam int SHIFT_POWER = 8;
    localparam int SHUNT_W = 20;
    localparam int BUS_W = 20;
    localparam int POWER_W = 24;
    // limit flag cells: index order
    localparam int N_LIMIT = 5;
    localparam int IDX_SHUNT_OVER = 0;
    localparam int IDX_SHUNT_UNDER = 1;
    localparam int IDX_BUS_OVER = 2;
    localparam int IDX_BUS_UNDER = 3;
    localparam int IDX_POWER_OVER = 4;
endpackage

/* File: lcaf_limit_compare.sv */
// comparators of fresh results against thresholds scaled to result lsb
module lcaf_limit_compare
    import lcaf_pkg::*;
(
    // results
    input wire logic signed [lcaf_pkg::SHUNT_W-1:0] shuntResult,
    input wire logic [lcaf_pkg::BUS_W-1:0] busResult,
    input wire logic [lcaf_pkg::POWER_W-1:0] powerResult,
    // thresholds
    input wire logic [15:0] shuntHigh,
    input wire logic [15:0] shuntLow,
    input wire logic [14:0] busHigh,
    input wire logic [14:0] busLow,
    input wire logic [15:0] powerLimit,
    input wire logic shuntRangeSelect,
    // hits
    output logic [lcaf_pkg::N_LIMIT-1:0] hit
);
    import lcaf_pkg::*;
    wire [4:0] shuntShift;
    wire signed [SHUNT_W-1:0] shuntHighExt;
    wire signed [SHUNT_W-1:0] shuntLowExt;
    wire signed [SHUNT_W-1:0] shuntHighScaled;
    wire signed [SHUNT_W-1:0] shuntLowScaled;
    wire [BUS_W-1:0] busHighScaled;
    wire [BUS_W-1:0] busLowScaled;
    wire [POWER_W-1:0] powerScaled;

    // both ranges happen to share the ratio, the select still picks it
    assign shuntShift = shuntRangeSelect ? 5'(SHIFT_SHUNT_NARROW)
                                         : 5'(SHIFT_SHUNT_WIDE);
    assign shuntHighExt = {{(SHUNT_W-16){shuntHigh[15]}}, shuntHigh};
    assign shuntLowExt = {{(SHUNT_W-16){shuntLow[15]}}, shuntLow};
    assign shuntHighScaled = shuntHighExt <<< shuntShift;
    assign shuntLowScaled = shuntLowExt <<< shuntShift;
    assign busHighScaled = {{(BUS_W-15){1'b0}}, busHigh} << SHIFT_BUS;
    assign busLowScaled = {{(BUS_W-15){1'b0}}, busLow} << SHIFT_BUS;
    assign powerScaled = {{(POWER_W-16){1'b0}}, powerLimit} << SHIFT_POWER;

    // signed for shunt, so zero exceeds any negative high threshold
    assign hit[IDX_SHUNT_OVER] = shuntResult > shuntHighScaled;
    assign hit[IDX_SHUNT_UNDER] = shuntResult < shuntLowScaled;
    assign hit[IDX_BUS_OVER] = busResult > busHighScaled;
    assign hit[IDX_BUS_UNDER] = busResult < busLowScaled;
    assign hit[IDX_POWER_OVER] = powerResult > powerScaled;
endmodule

/* File: lcaf_flag_cell.sv */
// one limit flag, transparent or latched until status read
module lcaf_flag_cell (
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // control
    input wire logic latchMode,
    input wire logic update,
    input wire logic hit,
    input wire logic clear,
    // flag
    output logic flag
);
    wire next_flag;

    // latched: a hit in the reading cycle survives the clear
    assign next_flag = latchMode ? ((update & hit) | (flag & ~clear))
                                 : (update ? hit : flag);

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            flag <= 1'b0;
        end else begin
            flag <= next_flag;
        end
    end
endmodule

/* File: lcaf_limit_alert.sv */
// limit comparison, diagnostic flags and threshold registers
module lcaf_limit_alert
    import lcaf_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // register access from the serial interface
    input wire logic [lcaf_pkg::ADDR_W-1:0] regAddr,
    input wire logic regWrite,
    input wire logic [15:0] regWriteData,
    input wire logic regRead,
    output logic [15:0] regReadData,
    output logic regReadValid,
    // measurement results
    input wire logic shuntValid,
    input wire logic signed [lcaf_pkg::SHUNT_W-1:0] shuntResult,
    input wire logic busValid,
    input wire logic [lcaf_pkg::BUS_W-1:0] busResult,
    input wire logic powerValid,
    input wire logic [lcaf_pkg::POWER_W-1:0] powerResult,
    // conversion and configuration
    input wire logic conversionStart,
    input wire logic conversionDone,
    input wire logic shuntRangeSelect,
    input wire logic [15:0] powerLimit,
    input wire logic trimChecksumError,
    // alarms
    output logic alertActive,
    output logic shuntOverAlarm
);
    import lcaf_pkg::*;

    logic [15:0] shuntHigh;
    logic [15:0] shuntLow;
    logic [14:0] busHigh;
    logic [14:0] busLow;
    logic alertLatchSelect;
    logic conversionDoneFlag;
    logic trimMemoryOk;
    logic [N_LIMIT-1:0] limitFlag;
    logic [N_LIMIT-1:0] cmpHit;

    wire wrShuntHigh;
    wire wrShuntLow;
    wire wrBusHigh;
    wire wrBusLow;
    wire wrStatus;
    wire statusRead;
    wire [N_LIMIT-1:0] cellUpdate;
    wire convClear;
    wire next_conversionDoneFlag;
    wire next_trimMemoryOk;
    wire [15:0] statusWord;
    wire [15:0] readMux;
    wire [15:0] next_regReadData;
    wire next_alertActive;

    // address decode
    assign wrShuntHigh = regWrite && (regAddr == ADDR_SHUNT_HIGH);
    assign wrShuntLow = regWrite && (regAddr == ADDR_SHUNT_LOW);
    assign wrBusHigh = regWrite && (regAddr == ADDR_BUS_HIGH);
    assign wrBusLow = regWrite && (regAddr == ADDR_BUS_LOW);
    assign wrStatus = regWrite && (regAddr == ADDR_STATUS);
    assign statusRead = regRead && (regAddr == ADDR_STATUS);

    // threshold registers; bus bit 15 is never stored
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            shuntHigh <= RST_SHUNT_HIGH;
            shuntLow <= RST_SHUNT_LOW;
            busHigh <= RST_BUS_HIGH;
            busLow <= RST_BUS_LOW;
        end else begin
            if (wrShuntHigh) begin
                shuntHigh <= regWriteData;
            end
            if (wrShuntLow) begin
                shuntLow <= regWriteData;
            end
            if (wrBusHigh) begin
                busHigh <= regWriteData[14:0];
            end
            if (wrBusLow) begin
                busLow <= regWriteData[14:0];
            end
        end
    end

    // only the latch select is writable; status bits belong to hardware
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            alertLatchSelect <= RST_LATCH;
        end else if (wrStatus) begin
            alertLatchSelect <= regWriteData[BIT_LATCH];
        end
    end

    lcaf_limit_compare u_compare (
        .shuntResult(shuntResult),
        .busResult(busResult),
        .powerResult(powerResult),
        .shuntHigh(shuntHigh),
        .shuntLow(shuntLow),
        .busHigh(busHigh),
        .busLow(busLow),
        .powerLimit(powerLimit),
        .shuntRangeSelect(shuntRangeSelect),
        .hit(cmpHit)
    );

    // each flag refreshes only when its own measurement completes
    assign cellUpdate[IDX_SHUNT_OVER] = shuntValid;
    assign cellUpdate[IDX_SHUNT_UNDER] = shuntValid;
    assign cellUpdate[IDX_BUS_OVER] = busValid;
    assign cellUpdate[IDX_BUS_UNDER] = busValid;
    assign cellUpdate[IDX_POWER_OVER] = powerValid;

    genvar gi;
    generate
        for (gi = 0; gi < N_LIMIT; gi = gi + 1) begin : g_flag
            lcaf_flag_cell u_cell (
                .clk_sys(clk_sys),
                .reset(reset),
                .latchMode(alertLatchSelect),
                .update(cellUpdate[gi]),
                .hit(cmpHit[gi]),
                .clear(statusRead),
                .flag(limitFlag[gi])
            );
        end
    endgenerate

    // transparent mode has no read clear, the next start clears it
    assign convClear = alertLatchSelect ? (statusRead | conversionStart)
                                        : conversionStart;
    assign next_conversionDoneFlag = conversionDone
                                   | (conversionDoneFlag & ~convClear);

    // a checksum error is sticky until reset
    assign next_trimMemoryOk = trimMemoryOk & ~trimChecksumError;

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            conversionDoneFlag <= 1'b0;
            trimMemoryOk <= RST_MEM_OK;
        end else begin
            conversionDoneFlag <= next_conversionDoneFlag;
            trimMemoryOk <= next_trimMemoryOk;
        end
    end

    // status word assembly; unassigned bits read zero
    assign statusWord = {alertLatchSelect, 8'h00,
                         limitFlag[IDX_SHUNT_OVER],
                         limitFlag[IDX_SHUNT_UNDER],
                         limitFlag[IDX_BUS_OVER],
                         limitFlag[IDX_BUS_UNDER],
                         limitFlag[IDX_POWER_OVER],
                         conversionDoneFlag,
                         trimMemoryOk};

    assign readMux = (regAddr == ADDR_STATUS) ? statusWord :
                     (regAddr == ADDR_SHUNT_HIGH) ? shuntHigh :
                     (regAddr == ADDR_SHUNT_LOW) ? shuntLow :
                     (regAddr == ADDR_BUS_HIGH) ? {1'b0, busHigh} :
                     (regAddr == ADDR_BUS_LOW) ? {1'b0, busLow} :
                     16'h0000;

    // read data holds the pre-clear status, taken in the clearing cycle
    assign next_regReadData = regRead ? readMux : regReadData;

    // alert lags the flags by one cycle, kept for a registered output
    assign next_alertActive = |limitFlag;

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            regReadData <= 16'h0000;
            regReadValid <= 1'b0;
            alertActive <= 1'b0;
            shuntOverAlarm <= 1'b0;
        end else begin
            regReadData <= next_regReadData;
            regReadValid <= regRead;
            alertActive <= next_alertActive;
            shuntOverAlarm <= limitFlag[IDX_SHUNT_OVER];
        end
    end

    // checks next to the logic they guard
    a_shunt_under_set: assert property (
        @(posedge clk_sys) disable iff (reset)
        (shuntValid && cmpHit[IDX_SHUNT_UNDER])
        |=> limitFlag[IDX_SHUNT_UNDER])
        else $error("shunt under flag not set");

    a_bus_over_set: assert property (
        @(posedge clk_sys) disable iff (reset)
        (busValid && (busResult > {1'b0, busHigh, 4'h0}))
        |=> limitFlag[IDX_BUS_OVER])
        else $error("bus over flag not set");

    a_bus_under_set: assert property (
        @(posedge clk_sys) disable iff (reset)
        (busValid && (busResult < {1'b0, busLow, 4'h0}))
        |=> statusWord[BIT_BUS_UNDER])
        else $error("bus under flag not set");

    a_power_over_set: assert property (
        @(posedge clk_sys) disable iff (reset)
        (powerValid && (powerResult > {powerLimit, 8'h00}))
        |=> limitFlag[IDX_POWER_OVER])
        else $error("power over flag not set");

    a_shunt_over_set: assert property (
        @(posedge clk_sys) disable iff (reset)
        (shuntValid && (shuntResult > $signed({shuntHigh, 4'h0})))
        |=> statusWord[BIT_SHUNT_OVER])
        else $error("shunt over flag not set");

    a_conv_done_set: assert property (
        @(posedge clk_sys) disable iff (reset)
        conversionDone |=> statusWord[BIT_CONV_DONE])
        else $error("conversion flag not set");

    a_conv_read_clear: assert property (
        @(posedge clk_sys) disable iff (reset)
        (alertLatchSelect && statusRead && !conversionDone)
        |=> !conversionDoneFlag)
        else $error("conversion flag not cleared by read");

    a_conv_start_clear: assert property (
        @(posedge clk_sys) disable iff (reset)
        (conversionStart && !conversionDone) |=> !conversionDoneFlag)
        else $error("conversion flag not cleared by start");

    a_latch_read_clear: assert property (
        @(posedge clk_sys) disable iff (reset)
        (alertLatchSelect && statusRead && !shuntValid && !busValid
         && !powerValid) |=> (limitFlag == '0))
        else $error("latched limit flags not cleared by read");

    a_status_read_data: assert property (
        @(posedge clk_sys) disable iff (reset)
        statusRead |=> (regReadData == $past(statusWord)))
        else $error("status read did not return the pre-clear flags");

    a_latch_hold: assert property (
        @(posedge clk_sys) disable iff (reset)
        (alertLatchSelect && !wrStatus && !statusRead
         && limitFlag[IDX_BUS_OVER]) |=> limitFlag[IDX_BUS_OVER])
        else $error("latched flag dropped without read");

    a_transparent_follow: assert property (
        @(posedge clk_sys) disable iff (reset)
        (!alertLatchSelect && busValid)
        |=> (limitFlag[IDX_BUS_UNDER] == $past(cmpHit[IDX_BUS_UNDER])))
        else $error("transparent flag does not follow compare");

    a_alert_any_flag: assert property (
        @(posedge clk_sys) disable iff (reset)
        (limitFlag != '0) |=> alertActive)
        else $error("alert not raised by a set flag");

    a_mem_error_sticky: assert property (
        @(posedge clk_sys) disable iff (reset)
        trimChecksumError |=> !trimMemoryOk [*3])
        else $error("memory ok bit not held low after error");

    a_mem_ok_hold: assert property (
        @(posedge clk_sys) disable iff (reset)
        (trimMemoryOk && !trimChecksumError) |=> trimMemoryOk)
        else $error("memory ok bit dropped without error");

    a_shunt_zero_trip: assert property (
        @(posedge clk_sys) disable iff (reset)
        (shuntValid && (shuntResult == '0) && shuntHigh[15])
        |=> ##1 shuntOverAlarm)
        else $error("zero shunt result did not trip negative threshold");

    a_shunt_high_write: assert property (
        @(posedge clk_sys) disable iff (reset)
        wrShuntHigh |=> (shuntHigh == $past(regWriteData)))
        else $error("shunt high threshold write lost");

    a_bus_msb_zero: assert property (
        @(posedge clk_sys) disable iff (reset)
        (regRead && ((regAddr == ADDR_BUS_HIGH) || (regAddr == ADDR_BUS_LOW)))
        |=> (regReadValid && !regReadData[15]))
        else $error("bus threshold bit 15 read as one");

    a_reset_values: assert property (
        @(posedge clk_sys)
        reset |=> ((shuntHigh == RST_SHUNT_HIGH) && (shuntLow == RST_SHUNT_LOW)
                   && (busHigh == RST_BUS_HIGH) && (busLow == RST_BUS_LOW)
                   && trimMemoryOk))
        else $error("threshold reset values wrong");
endmodule

/* File: lcaf_host_model.sv */
// host controller model: drives the register strobe bus
module lcaf_host_model
    import lcaf_pkg::*;
(
    // clock
    input wire logic clk_sys,
    // register requests
    output logic [lcaf_pkg::ADDR_W-1:0] regAddr,
    output logic regWrite,
    output logic [15:0] regWriteData,
    output logic regRead,
    // read answer
    input wire logic [15:0] regReadData,
    input wire logic regReadValid
);
    timeunit 1ns;
    timeprecision 1ps;
    import lcaf_pkg::*;
    initial begin
        regAddr = '0;
        regWrite = 1'b0;
        regWriteData = 16'h0000;
        regRead = 1'b0;
    end
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        regAddr <= a;
        regWriteData <= d;
        regWrite <= 1'b1;
        @(posedge clk_sys);
        regWrite <= 1'b0;
    endtask
    // answer is registered: taken at the next edge, where the valid stands
    task automatic rd(input logic [ADDR_W-1:0] a, output logic [15:0] d,
                      output logic v);
        @(posedge clk_sys);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge clk_sys);
        regRead <= 1'b0;
        @(posedge clk_sys);
        d = regReadData;
        v = regReadValid;
    endtask
endmodule

/* File: test_limit_compare_alert_flags.sv */
// testbench of the limit compare and alert flag block
module test_limit_compare_alert_flags;
    timeunit 1ns;
    timeprecision 1ps;
    import lcaf_pkg::*;
    logic clk_sys, reset, regWrite, regRead, regReadValid;
    logic [ADDR_W-1:0] regAddr;
    logic [15:0] regWriteData, regReadData, powerLimit;
    logic shuntValid, busValid, powerValid, conversionStart;
    logic conversionDone, shuntRangeSelect, trimChecksumError;
    logic signed [SHUNT_W-1:0] shuntResult;
    logic [BUS_W-1:0] busResult;
    logic [POWER_W-1:0] powerResult;
    logic alertActive, shuntOverAlarm;
    logic [15:0] sh, sl, pl, t;
    logic [14:0] bh, bl;
    bit k;
    int errors, n_tests;

    lcaf_host_model host (.clk_sys, .regAddr, .regWrite, .regWriteData,
        .regRead, .regReadData, .regReadValid);
    lcaf_limit_alert DUT (.clk_sys, .reset, .regAddr, .regWrite,
        .regWriteData, .regRead, .regReadData, .regReadValid, .shuntValid,
        .shuntResult, .busValid, .busResult, .powerValid, .powerResult,
        .conversionStart, .conversionDone, .shuntRangeSelect, .powerLimit,
        .trimChecksumError, .alertActive, .shuntOverAlarm);

    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end

    task automatic chk_word(input logic [15:0] g, input logic [15:0] e);
        n_tests++;
        if (g !== e) begin
            errors++;
            $display("mismatch %0t word got %h exp %h", $time, g, e);
        end
    endtask
    task automatic chk_bit(input logic g, input logic e);
        n_tests++;
        if (g !== e) begin
            errors++;
            $display("mismatch %0t bit got %b exp %b", $time, g, e);
        end
    endtask
    task automatic rdc(input logic [ADDR_W-1:0] a, input logic [15:0] e);
        logic [15:0] d;
        logic v;
        host.rd(a, d, v);
        chk_bit(v, 1'b1);
        chk_word(d, e);
    endtask
    task automatic meas(input logic signed [19:0] s, input logic [19:0] b,
                        input logic [23:0] p);
        @(posedge clk_sys);
        {shuntValid, busValid, powerValid} <= 3'b111;
        shuntResult <= s;
        busResult <= b;
        powerResult <= p;
        @(posedge clk_sys);
        {shuntValid, busValid, powerValid} <= 3'b000;
    endtask
    // k: bit 2 checksum error, bit 1 start, bit 0 done
    task automatic pulse(input logic [2:0] k);
        @(posedge clk_sys);
        {trimChecksumError, conversionStart, conversionDone} <= k;
        @(posedge clk_sys);
        {trimChecksumError, conversionStart, conversionDone} <= 3'b000;
    endtask
    function automatic int off();
        return int'($urandom_range(4)) - 2;
    endfunction
    function automatic logic [15:0] exp_stat(input logic [15:0] sh, sl,
        input logic [14:0] bh, bl, input logic [15:0] pl,
        input logic signed [19:0] s, input logic [19:0] b,
        input logic [23:0] p);
        logic so, su, bo, bu, po;
        so = s > $signed({sh, 4'h0});
        su = s < $signed({sl, 4'h0});
        bo = b > {1'b0, bh, 4'h0};
        bu = b < {1'b0, bl, 4'h0};
        po = p > {pl, 8'h00};
        return {9'h000, so, su, bo, bu, po, 2'b01};
    endfunction
    // transparent mode: flags equal the compare of this measurement
    task automatic trial(input logic [15:0] sh, sl, input logic [14:0] bh,
        bl, input logic [15:0] pl, input logic signed [19:0] s,
        input logic [19:0] b, input logic [23:0] p);
        logic [15:0] e;
        e = exp_stat(sh, sl, bh, bl, pl, s, b, p);
        host.wr(ADDR_SHUNT_HIGH, sh);
        host.wr(ADDR_SHUNT_LOW, sl);
        host.wr(ADDR_BUS_HIGH, {1'b0, bh});
        host.wr(ADDR_BUS_LOW, {1'b0, bl});
        powerLimit <= pl;
        shuntRangeSelect <= 1'($urandom_range(1));
        meas(s, b, p);
        rdc(ADDR_STATUS, e);
        chk_bit(alertActive, |e[6:2]);
        chk_bit(shuntOverAlarm, e[6]);
    endtask
    task end_sim;
        $display("comparisons %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    initial begin
        #100000;
        errors++;
        end_sim();
    end

    initial begin
        reset = 1'b1;
        {shuntValid, busValid, powerValid} = 3'b000;
        {trimChecksumError, conversionStart, conversionDone} = 3'b000;
        shuntResult = '0;
        busResult = '0;
        powerResult = '0;
        powerLimit = 16'hFFFF;
        shuntRangeSelect = 1'b0;
        errors = 0;
        n_tests = 0;
        void'($urandom(32'h494E));
        repeat (12) @(posedge clk_sys);
        reset <= 1'b0;
        rdc(ADDR_STATUS, 16'h0001);
        rdc(ADDR_SHUNT_HIGH, 16'h7FFF);
        rdc(ADDR_SHUNT_LOW, 16'h8000);
        rdc(ADDR_BUS_HIGH, 16'h7FFF);
        rdc(ADDR_BUS_LOW, 16'h0000);
        rdc(6'h20, 16'h0000);
        $display("test reset_values done");
        host.wr(ADDR_BUS_HIGH, 16'hFFFF);
        rdc(ADDR_BUS_HIGH, 16'h7FFF);
        host.wr(ADDR_BUS_LOW, 16'hFFFF);
        rdc(ADDR_BUS_LOW, 16'h7FFF);
        $display("test bus_reserved_bit done");
        // high kept less negative than low when both are negative
        trial(16'hFFFF, 16'h8000, 15'h0100, 15'h0000, 16'h0100, 20'sh00000,
              20'h00800, 24'h000000);
        repeat (24) begin
            sh = 16'($urandom);
            sl = 16'($urandom);
            if ($signed(sl) > $signed(sh)) begin
                t = sh;
                sh = sl;
                sl = t;
            end
            bh = 15'($urandom);
            bl = 15'($urandom);
            pl = 16'($urandom);
            k = 1'($urandom_range(1));
            trial(sh, sl, bh, bl, pl, $signed({k ? sh : sl, 4'h0}) +
                20'(off()), {1'b0, k ? bh : bl, 4'h0} + 20'(off()),
                {pl, 8'h00} + 24'(off()));
        end
        $display("test random_limits done");
        // still transparent: a quiet result clears the random flags first
        trial(16'h7FFF, 16'h8000, 15'h0010, 15'h0000, 16'hFFFF, 20'sh00000,
              20'h00000, 24'h000000);
        host.wr(ADDR_STATUS, 16'h8000);
        meas(20'sh00000, 20'h00200, 24'h000000);
        meas(20'sh00000, 20'h00000, 24'h000000);
        @(posedge clk_sys);
        #1;
        chk_bit(alertActive, 1'b1);
        rdc(ADDR_STATUS, 16'h8011);
        rdc(ADDR_STATUS, 16'h8001);
        $display("test latched_limits done");
        pulse(3'b001);
        rdc(ADDR_STATUS, 16'h8003);
        rdc(ADDR_STATUS, 16'h8001);
        pulse(3'b001);
        pulse(3'b010);
        rdc(ADDR_STATUS, 16'h8001);
        host.wr(ADDR_STATUS, 16'h0000);
        pulse(3'b001);
        rdc(ADDR_STATUS, 16'h0003);
        pulse(3'b010);
        $display("test conversion_flag done");
        pulse(3'b100);
        rdc(ADDR_STATUS, 16'h0000);
        rdc(ADDR_STATUS, 16'h0000);
        $display("test trim_error done");
        @(posedge clk_sys);
        reset <= 1'b1;
        repeat (2) @(posedge clk_sys);
        reset <= 1'b0;
        rdc(ADDR_STATUS, 16'h0001);
        rdc(ADDR_BUS_HIGH, 16'h7FFF);
        $display("test mid_reset done");
        end_sim();
    end
endmodule
